//--- hdl/adcc_top.sv
// Purpose: Conversion control of a successive-approximation converter, APB slave.
// Assumes: cmp_in is the comparator verdict on dac_code, valid at each converter tick.
// Notes:   APB answers with one wait state; every output comes from a flip-flop.
// Behaviour
// - Converter clock is core clock divided by 1, 2, 4, 8 or 16.
// - Conversions never exceed one hundred thousand samples per second.
// - Two-bit start-mode field picks software busy write or timer overflow.
// - Software mode: writing one to busy launches one conversion.
// - Busy reads one during conversion, clears itself when finished.
// - Busy falling sets done flag and requests interrupt when enabled.
// - Each finished result lands in the readable result register.
// - Track mode zero tracks continuously except while converting.
// - Track mode one, software start: track three converter clocks after busy write.
// - Track mode one, timer start: track three converter clocks after overflow.
// - Tracking shuts down while the chip is in standby (low_power_standby high).
// - Reference field: 00 external pin, 11 supply, others reserved, reset 00.
`timescale 1ns/1ps
module adcc_top
   import adcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_overflow,
   input wire logic low_power_standby,
   input wire logic cmp_in,
   output logic [7:0] dac_code,
   output logic track_en,
   output logic [1:0] ref_sel,
   output logic irq
);
`include "adcc_consts.svh"

   localparam int RB = `ADCC_RESULT_BITS;
   localparam logic [7:0] MIN_PERIOD = 8'(`ADCC_MIN_PERIOD_CYC);
   localparam logic [1:0] TRACK_LAST = 2'(`ADCC_TRACK_CLOCKS - 1);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic acc_first;
   logic wr_go;
   logic wr_lane;
   logic hit_ref, hit_cfg, hit_ctrl, hit_res, hit_stat, hit_mask, hit_any;

   // Setup and first access cycle prepare; pready high marks the taking edge
   assign acc_first = psel & penable & ~pready;
   assign wr_go = psel & penable & pready & pwrite;
   assign wr_lane = pstrb[0];

   always_comb begin
      hit_ref = 1'b0;
      hit_cfg = 1'b0;
      hit_ctrl = 1'b0;
      hit_res = 1'b0;
      hit_stat = 1'b0;
      hit_mask = 1'b0;
      if (paddr == `ADCC_ADDR_REF) begin
         hit_ref = 1'b1;
      end else if (paddr == `ADCC_ADDR_CFG) begin
         hit_cfg = 1'b1;
      end else if (paddr == `ADCC_ADDR_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (paddr == `ADCC_ADDR_RESULT) begin
         hit_res = 1'b1;
      end else if (paddr == `ADCC_ADDR_IRQ_STAT) begin
         hit_stat = 1'b1;
      end else if (paddr == `ADCC_ADDR_IRQ_MASK) begin
         hit_mask = 1'b1;
      end
   end
   assign hit_any = hit_ref | hit_cfg | hit_ctrl | hit_res | hit_stat | hit_mask;

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   logic [2:0] div_sel_q;
   logic [1:0] start_mode_q;
   logic track_mode_q;
   logic [1:0] mask_q;
   logic [RB-1:0] result_q;

   // Reference select; only the low two bits exist
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_sel <= `ADCC_RST_REF;
      end else if (wr_go && wr_lane && hit_ref) begin
         ref_sel <= pwdata[1:0];
      end
   end

   // Divider, start mode, track mode and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_sel_q <= `ADCC_RST_CFG;
         start_mode_q <= `ADCC_RST_STM;
         track_mode_q <= 1'b0;
         mask_q <= `ADCC_RST_MASK;
      end else if (wr_go && wr_lane) begin
         if (hit_cfg) begin
            div_sel_q <= pwdata[2:0];
         end
         if (hit_ctrl) begin
            start_mode_q <= pwdata[`ADCC_CTRL_STM_HI:`ADCC_CTRL_STM_LO];
            track_mode_q <= pwdata[`ADCC_CTRL_TRACK];
         end
         if (hit_mask) begin
            mask_q <= pwdata[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Start decode
   // ----------------------------------------------------------------
   adcc_state_type state_q;
   logic busy_q;
   logic soft_start, timer_start, start_req, start_go, overrun;
   logic timer_mode;

   // Reserved start codes behave as software start
   assign timer_mode = (start_mode_q == ADCC_START_TIMER);
   assign soft_start = wr_go && wr_lane && hit_ctrl && pwdata[`ADCC_CTRL_BUSY]
                       && !timer_mode;
   assign timer_start = timer_overflow && timer_mode;
   assign start_req = soft_start | timer_start;
   assign start_go = start_req && (state_q == ADCC_ST_IDLE);
   // A start landing while busy is dropped and flagged
   assign overrun = start_req && (state_q != ADCC_ST_IDLE);

   // ----------------------------------------------------------------
   // Converter clock
   // ----------------------------------------------------------------
   logic conv_tick;

   adcc_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .restart(start_go),
      .div_sel(div_sel_q),
      .tick(conv_tick)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   logic [1:0] trk_cnt_q;
   logic [2:0] bit_idx_q;
   logic [7:0] pace_q;
   logic [RB-1:0] trial_d;
   logic done_evt;

   // Next trial word: keep or drop the bit under test, raise the next one
   always_comb begin
      trial_d = dac_code;
      trial_d[bit_idx_q] = cmp_in;
      if (bit_idx_q != 3'h0) begin
         trial_d[3'(bit_idx_q - 3'h1)] = 1'b1;
      end
   end

   // Busy falls when pacing ends; the same edge raises the done event
   assign done_evt = (state_q == ADCC_ST_PACE) && (pace_q >= 8'(MIN_PERIOD - 8'h01));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ADCC_ST_IDLE;
         trk_cnt_q <= 2'h0;
         bit_idx_q <= 3'h0;
         dac_code <= 8'h00;
         result_q <= 8'h00;
      end else begin
         case (state_q)
            ADCC_ST_IDLE: begin
               if (start_go) begin
                  trk_cnt_q <= 2'h0;
                  bit_idx_q <= 3'(RB - 1);
                  dac_code <= 8'h80;
                  // Low-power mode inserts a fixed track window first
                  state_q <= track_mode_q ? ADCC_ST_TRACK : ADCC_ST_CONVERT;
               end
            end
            ADCC_ST_TRACK: begin
               if (conv_tick) begin
                  trk_cnt_q <= 2'(trk_cnt_q + 2'h1);
                  if (trk_cnt_q == TRACK_LAST) begin
                     state_q <= ADCC_ST_CONVERT;
                  end
               end
            end
            ADCC_ST_CONVERT: begin
               if (conv_tick) begin
                  dac_code <= trial_d;
                  if (bit_idx_q == 3'h0) begin
                     result_q <= trial_d;
                     state_q <= ADCC_ST_PACE;
                  end else begin
                     bit_idx_q <= 3'(bit_idx_q - 3'h1);
                  end
               end
            end
            ADCC_ST_PACE: begin
               if (done_evt) begin
                  state_q <= ADCC_ST_IDLE;
               end
            end
            default: begin
               state_q <= ADCC_ST_IDLE;
            end
         endcase
      end
   end

   // Busy flag mirrors the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
      end else if (start_go) begin
         busy_q <= 1'b1;
      end else if (done_evt) begin
         busy_q <= 1'b0;
      end
   end

   // Sample pacing; a fast converter clock still waits the least period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pace_q <= 8'h00;
      end else if (start_go) begin
         pace_q <= 8'h00;
      end else if (busy_q && pace_q != 8'hFF) begin
         pace_q <= 8'(pace_q + 8'h01);
      end
   end

   // ----------------------------------------------------------------
   // Track and hold
   // ----------------------------------------------------------------
   // Standby overrides both modes to save the input buffer current
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         track_en <= 1'b0;
      end else if (low_power_standby) begin
         track_en <= 1'b0;
      end else if (track_mode_q) begin
         track_en <= (state_q == ADCC_ST_TRACK);
      end else begin
         track_en <= !busy_q;
      end
   end

   // ----------------------------------------------------------------
   // Event flags and interrupt
   // ----------------------------------------------------------------
   logic [`ADCC_IRQ_BITS-1:0] stat_q;
   logic [`ADCC_IRQ_BITS-1:0] evt;
   logic [`ADCC_IRQ_BITS-1:0] clr;

   assign evt[`ADCC_IRQ_DONE] = done_evt;
   assign evt[`ADCC_IRQ_OVERRUN] = overrun;
   // Done flag clears by writing one at either the control or status word
   assign clr[`ADCC_IRQ_DONE] = wr_go && wr_lane && ((hit_stat && pwdata[`ADCC_IRQ_DONE])
                                || (hit_ctrl && pwdata[`ADCC_CTRL_DONE]));
   assign clr[`ADCC_IRQ_OVERRUN] = wr_go && wr_lane && hit_stat
                                   && pwdata[`ADCC_IRQ_OVERRUN];

   // Sticky bits; a set in the clearing cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < `ADCC_IRQ_BITS; gi++) begin : g_stat
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stat_q[gi] <= 1'b0;
            end else if (evt[gi]) begin
               stat_q[gi] <= 1'b1;
            end else if (clr[gi]) begin
               stat_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Interrupt level; follows flags one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_q & mask_q);
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ref) begin
         rd_mux[1:0] = ref_sel;
      end else if (hit_cfg) begin
         rd_mux[2:0] = div_sel_q;
      end else if (hit_ctrl) begin
         rd_mux[`ADCC_CTRL_BUSY] = busy_q;
         rd_mux[`ADCC_CTRL_DONE] = stat_q[`ADCC_IRQ_DONE];
         rd_mux[`ADCC_CTRL_STM_HI:`ADCC_CTRL_STM_LO] = start_mode_q;
         rd_mux[`ADCC_CTRL_TRACK] = track_mode_q;
      end else if (hit_res) begin
         rd_mux[RB-1:0] = result_q;
      end else if (hit_stat) begin
         rd_mux[`ADCC_IRQ_BITS-1:0] = stat_q;
      end else if (hit_mask) begin
         rd_mux[`ADCC_IRQ_BITS-1:0] = mask_q;
      end
   end

   // One wait state: data and error load on the same edge that raises pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= acc_first;
         if (acc_first) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !hit_any;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

endmodule

//--- hdl/adcc_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the converter control.
// Assumes: 32-bit APB data, each register one aligned word at four times its index.
// Notes:   Definitions only.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define ADCC_IDX_REF 8'hD1
`define ADCC_IDX_CFG 8'hBC
`define ADCC_IDX_CTRL 8'hE8
`define ADCC_IDX_RESULT 8'hBE
`define ADCC_IDX_IRQ_STAT 8'hC8
`define ADCC_IDX_IRQ_MASK 8'hC9
`define ADCC_ADDR_REF 12'h0344
`define ADCC_ADDR_CFG 12'h02F0
`define ADCC_ADDR_CTRL 12'h03A0
`define ADCC_ADDR_RESULT 12'h02F8
`define ADCC_ADDR_IRQ_STAT 12'h0320
`define ADCC_ADDR_IRQ_MASK 12'h0324

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCC_CTRL_BUSY 0
`define ADCC_CTRL_DONE 1
`define ADCC_CTRL_STM_LO 2
`define ADCC_CTRL_STM_HI 3
`define ADCC_CTRL_TRACK 4
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_OVERRUN 1
`define ADCC_IRQ_BITS 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADCC_RST_REF 2'h0
`define ADCC_RST_CFG 3'h0
`define ADCC_RST_STM 2'h0
`define ADCC_RST_MASK 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCC_CLK_HZ 20000000
`define ADCC_MAX_SPS 100000
`define ADCC_MIN_PERIOD_CYC ((`ADCC_CLK_HZ + `ADCC_MAX_SPS - 1) / `ADCC_MAX_SPS)
`define ADCC_TRACK_CLOCKS 3
`define ADCC_RESULT_BITS 8
`define ADCC_DIV_SEL_MAX 3'h4

`endif

//--- hdl/adcc_pkg.sv
// Purpose: Types shared by the converter control.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in adcc_consts.svh.
package adcc_pkg;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ADCC_ST_IDLE,
      ADCC_ST_TRACK,
      ADCC_ST_CONVERT,
      ADCC_ST_PACE
   } adcc_state_type;

   // Start source codes of the start-mode field
   typedef enum logic [1:0] {
      ADCC_START_SOFT,
      ADCC_START_TIMER,
      ADCC_START_RSV2,
      ADCC_START_RSV3
   } adcc_start_type;

endpackage

//--- hdl/adcc_divider.sv
// Purpose: Conversion clock tick from the core clock, ratio 1, 2, 4, 8 or 16.
// Assumes: restart is a one-cycle pulse from the sequencer.
// Notes:   Tick is one core clock wide, so the ratio-1 case ticks every cycle.
`timescale 1ns/1ps
module adcc_divider
   import adcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   input wire logic [2:0] div_sel,
   output logic tick
);
`include "adcc_consts.svh"

   logic [3:0] cnt_q;
   logic [3:0] limit;
   logic [2:0] sel_clamped;

   // ----------------------------------------------------------------
   // Ratio decode
   // ----------------------------------------------------------------
   // Codes above four clamp to ratio sixteen rather than stop the converter clock
   assign sel_clamped = (div_sel > `ADCC_DIV_SEL_MAX) ? `ADCC_DIV_SEL_MAX : div_sel;
   assign limit = 4'(5'((5'h01 << sel_clamped) - 5'h01));

   // Counter; restart realigns so tracking gets whole converter clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         tick <= 1'b0;
      end else if (restart) begin
         cnt_q <= 4'h0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt_q == limit);
         cnt_q <= (cnt_q == limit) ? 4'h0 : 4'(cnt_q + 4'h1);
      end
   end

endmodule

//--- dv/adcc_top_assertions.sv
// Purpose: Port-level checks of the converter control.
// Assumes: Sees only the top module's ports, one clock domain.
// Notes:   Bound to every adcc_top instance.
`timescale 1ns/1ps
`include "adcc_consts.svh"
module adcc_top_assertions
   import adcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic low_power_standby,
   input wire logic track_en,
   input wire logic [1:0] ref_sel,
   input wire logic irq
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Taken transfer to the reference register
   wire logic taken;
   wire logic wr_ref;
   assign taken = psel && penable && pready;
   assign wr_ref = taken && pwrite && pstrb[0] && (paddr == `ADCC_ADDR_REF);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle");
   chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not in second access cycle");
   chk_idle_quiet: assert property (!psel |=> !pready)
      else $error("pready without a request");
   chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error answer malformed");
   chk_ref_write: assert property (wr_ref |=> ref_sel == $past(pwdata[1:0]))
      else $error("reference select not written");
   chk_ref_hold: assert property (!wr_ref |=> $stable(ref_sel))
      else $error("reference select changed without write");
   chk_ref_upper: assert property (taken && !pwrite && paddr == `ADCC_ADDR_REF
      |-> prdata[31:2] == 30'h0000_0000)
      else $error("reference upper bits not zero");
   chk_standby_track: assert property (low_power_standby && $past(low_power_standby)
      |-> !track_en)
      else $error("tracking during standby");
   chk_irq_fall: assert property ($fell(irq) |-> $past(taken && pwrite, 2))
      else $error("interrupt dropped without a write");

   // Main scenarios reached
   cover property ($rose(irq));
   cover property (pslverr);
   cover property ($rose(track_en));
endmodule

bind adcc_top adcc_top_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .low_power_standby(low_power_standby), .track_en(track_en), .ref_sel(ref_sel),
   .irq(irq));

//--- dv/adcc_testbench.sv
// Purpose: Self-checking bench of the converter control over APB.
// Assumes: One wait state answers; busy lasts at least 200 cycles.
// Notes:   Comparator held steady per conversion, so results are all ones or zeros.
`timescale 1ns/1ps
`include "adcc_consts.svh"
module testbench
   import adcc_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, timer_overflow, low_power_standby, cmp_in;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [3:0] pstrb;
   logic pready, pslverr, track_en, irq, err, last_irq, c;
   logic [7:0] dac_code, last_dac;
   logic [1:0] ref_sel, m;
   int fails, check_count, cyc, t_taken, t_irq, trk_cnt, ts;
   int chg[$];
   localparam logic [11:0] a_ctrl = `ADCC_ADDR_CTRL;
   localparam logic [11:0] a_stat = `ADCC_ADDR_IRQ_STAT;

   adcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_overflow(timer_overflow),
      .low_power_standby(low_power_standby), .cmp_in(cmp_in), .dac_code(dac_code),
      .track_en(track_en), .ref_sel(ref_sel), .irq(irq));

   // Clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Cycle stamps of trial-word steps, interrupt rise and tracking length
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      last_dac <= dac_code;
      last_irq <= irq;
      if (dac_code !== last_dac) chg.push_back(cyc);
      if (irq && !last_irq) t_irq <= cyc;
      if (track_en) trk_cnt <= trk_cnt + 1;
   end

   // ----------------------------------------------------------------
   // Tasks and functions
   // ----------------------------------------------------------------
   task automatic conclude();
      if (fails == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One transfer; a free edge before setup keeps drivers from double assignment
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      t_taken = cyc;
      if (n >= 16) fails++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Completion is judged by the done flag, not by busy
   task automatic wait_done();
      int n = 0;
      do begin
         apb(1'b0, a_ctrl, 32'h0000_0000);
         n++;
      end while (rd[1] !== 1'b1 && n < 200);
      if (n >= 200) fails++;
   endtask

   function automatic logic [31:0] ratio(input int s);
      return (s > 4) ? 32'h0000_0010 : (32'h0000_0001 << s);
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, timer_overflow, low_power_standby, cmp_in} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hF;
      {fails, check_count, cyc, trk_cnt, t_irq} = '0;
      last_dac = '0;
      last_irq = 1'b0;
      void'($urandom(65));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADCC_ADDR_REF, 0);
      chk("reference reset", 0, rd);
      apb(1'b0, a_ctrl, 0);
      chk("control reset", 0, rd);
      chk("idle tracking", 1, track_en);
      // All reference codes with random upper bits
      for (int i = 0; i < 4; i++) begin
         v = $urandom();
         v[1:0] = i[1:0];
         apb(1'b1, `ADCC_ADDR_REF, v);
         apb(1'b0, `ADCC_ADDR_REF, 0);
         chk("reference readback", {30'h0, v[1:0]}, rd);
         chk("reference pins", {30'h0, v[1:0]}, {30'h0, ref_sel});
      end
      // Byte lane zero off: the write must leave the register alone
      pstrb <= 4'hE;
      apb(1'b1, `ADCC_ADDR_REF, 0);
      pstrb <= 4'hF;
      apb(1'b0, `ADCC_ADDR_REF, 0);
      chk("lane-off write", 3, rd);
      apb(1'b0, 12'h004, 0);
      chk("unmapped error", 1, err);
      apb(1'b1, 12'(`ADCC_IDX_RESULT * 4), 32'h0000_005A);
      apb(1'b0, `ADCC_ADDR_RESULT, 0);
      chk("result read only", 0, rd);
      apb(1'b1, `ADCC_ADDR_IRQ_MASK, 1);
      // Divider sweep, including a selector beyond the last ratio
      for (int s = 0; s < 6; s++) begin
         apb(1'b1, `ADCC_ADDR_CFG, s);
         chg.delete();
         apb(1'b1, a_ctrl, 1);
         ts = t_taken;
         apb(1'b0, a_ctrl, 0);
         chk("busy during", 1, rd[0]);
         chk("hold while converting", 0, track_en);
         wait_done();
         chk("busy after", 0, rd[0]);
         repeat (2) @(posedge pclk);
         chk("interrupt", 1, irq);
         chk("sample pace", 1, (t_irq - ts) >= 200);
         chk("tick spacing", ratio(s), chg[2] - chg[1]);
         chk("final trial word", 0, dac_code);
         apb(1'b0, `ADCC_ADDR_RESULT, 0);
         chk("result zero", 0, rd);
         apb(1'b1, a_stat, 1);
         repeat (2) @(posedge pclk);
         chk("interrupt cleared", 0, irq);
      end
      // Random conversions over the software start codes
      for (int k = 0; k < 6; k++) begin
         c = 1'($urandom_range(1, 0));
         m = (k % 4 == 1) ? 2'd0 : 2'(k % 4);
         cmp_in <= c;
         apb(1'b1, `ADCC_ADDR_CFG, $urandom_range(4, 0));
         apb(1'b1, a_ctrl, {27'h0, 1'b0, m, 2'b01});
         wait_done();
         apb(1'b0, `ADCC_ADDR_RESULT, 0);
         chk("result", c ? 32'h0000_00FF : 32'h0000_0000, rd);
         apb(1'b1, a_stat, 1);
      end
      cmp_in <= 1'b0;
      // Masked interrupt, then unmask and clear through control
      apb(1'b1, `ADCC_ADDR_IRQ_MASK, 0);
      apb(1'b1, a_ctrl, 1);
      // A second start while busy is dropped and flagged
      apb(1'b1, a_ctrl, 1);
      wait_done();
      apb(1'b0, a_stat, 0);
      chk("overrun flag", 3, rd);
      apb(1'b1, a_stat, 2);
      repeat (2) @(posedge pclk);
      chk("masked interrupt", 0, irq);
      apb(1'b1, `ADCC_ADDR_IRQ_MASK, 1);
      repeat (2) @(posedge pclk);
      chk("unmasked interrupt", 1, irq);
      apb(1'b1, a_ctrl, 2);
      apb(1'b0, a_ctrl, 0);
      chk("done cleared", 0, rd[1]);
      chk("interrupt gone", 0, irq);
      // Standby gates tracking
      low_power_standby <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("standby tracking", 0, track_en);
      low_power_standby <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("tracking resumes", 1, track_en);
      // Low-power track: timer start, then software start, divide by 2
      apb(1'b1, `ADCC_ADDR_CFG, 1);
      apb(1'b1, a_ctrl, 32'h0000_0014);
      apb(1'b1, a_ctrl, 32'h0000_0015);
      apb(1'b0, a_ctrl, 0);
      chk("soft start ignored", 0, rd[0]);
      chk("no idle tracking", 0, track_en);
      trk_cnt = 0;
      @(posedge pclk);
      timer_overflow <= 1'b1;
      @(posedge pclk);
      timer_overflow <= 1'b0;
      wait_done();
      chk("timer track window", 1, trk_cnt >= 5 && trk_cnt <= 7);
      apb(1'b1, a_stat, 1);
      apb(1'b1, a_ctrl, 32'h0000_0010);
      repeat (2) @(posedge pclk);
      trk_cnt = 0;
      apb(1'b1, a_ctrl, 32'h0000_0011);
      wait_done();
      chk("soft track window", 1, trk_cnt >= 5 && trk_cnt <= 7);
      conclude();
   end

   // Watchdog, far beyond the expected run length
   initial begin
      #(50 * 20000);
      fails++;
      conclude();
   end
endmodule
